// ===== hdl/lpmc_top.sv
// lpmc_top: low-power mode and clock-domain enable controller
// assumes one 50 MHz clock; clock enables drive gates outside this block,
// idle_exec is a one-cycle pulse from the cpu, registers over AXI4-Lite
`timescale 1ns/1ps

module lpmc_top (
	input  wire logic                           clk,
	input  wire logic                           rst,
	// cpu and interrupt side
	input  wire logic                           idle_exec,
	input  wire logic                           periph_irq,
	input  wire logic                           ext_irq,
	input  wire logic                           wakeup_irq,
	input  wire logic                           drive_protect_interrupt,
	// clock source side
	input  wire logic                           osc_ready,
	input  wire logic                           pll_lock,
	// clock and power enables
	output logic                                cpu_clk_en,
	output logic                                sys_clk_en,
	output logic                                cpu_clock_output_en,
	output logic                                watchdog_clock_en,
	output logic                                pll_en,
	output logic                                osc_en,
	output logic                                flash_pwr_en,
	output logic [lpmc_pkg::NUM_PCLK-1:0]       periph_clk_en,
	// AXI4-Lite slave
	input  wire logic [7:0]                     s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [31:0]                    s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [7:0]                     s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic [31:0]                         s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready
);

	// ----------------------------------------------------------------
	// state record
	// ----------------------------------------------------------------
	typedef struct packed {
		lpmc_pkg::lpmc_mode_t                mode;
		logic [1:0]                          depth;      // depth caught at idle
		logic [15:0]                         ctrl;       // system_control_status_one
		logic                                cpu_en;
		logic                                sys_en;
		logic                                wd_en;
		logic                                pll_on;
		logic                                osc_on;
		logic                                flash_on;
		logic [lpmc_pkg::NUM_PCLK-1:0]       pclk;
		logic [7:0]                          aw_addr;
		logic                                have_aw;
		logic [31:0]                         wdata;
		logic [3:0]                          wstrb;
		logic                                have_w;
		logic                                awready;
		logic                                wready;
		logic                                bvalid;
		logic [1:0]                          bresp;
		logic                                arready;
		logic                                rvalid;
		logic [31:0]                         rdata;
		logic [1:0]                          rresp;
	} lpmc_state_t;

	lpmc_state_t r_reg;
	lpmc_state_t r_next;

	logic wake;
	logic seq_start;
	logic seq_sys;
	logic seq_cpu;
	logic seq_busy;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// merge byte lanes of a write into a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
		logic [15:0] v;
		v = old;
		if (be[0]) v[7:0]  = d[7:0];
		if (be[1]) v[15:8] = d[15:8];
		return v;
	endfunction

	// depth field to the sleep state it selects
	function automatic lpmc_pkg::lpmc_mode_t depth_mode(input logic [1:0] d);
		if (d[1])      return lpmc_pkg::LPMC_DEEP;
		else if (d[0]) return lpmc_pkg::LPMC_MEDIUM;
		else           return lpmc_pkg::LPMC_LIGHT;
	endfunction

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	lpmc_wake_sel u_wake (
		.mode                    (r_reg.mode),
		.periph_irq              (periph_irq),
		.ext_irq                 (ext_irq),
		.wakeup_irq              (wakeup_irq),
		.drive_protect_interrupt (drive_protect_interrupt),
		.wake                    (wake)
	);

	// restart begins when the deepest sleep sees its wake source
	assign seq_start = (r_reg.mode == lpmc_pkg::LPMC_DEEP) && wake;

	lpmc_restart_seq u_seq (
		.clk         (clk),
		.rst         (rst),
		.start       (seq_start),
		.osc_ready   (osc_ready),
		.pll_lock    (pll_lock),
		.sys_release (seq_sys),
		.cpu_release (seq_cpu),
		.busy        (seq_busy)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		r_next = r_reg;

		// power state machine
		unique case (r_reg.mode)
			lpmc_pkg::LPMC_RUN: begin
				if (idle_exec) begin
					// depth taken only here, later depth writes do not change the sleep state
					r_next.depth = r_reg.ctrl[lpmc_pkg::SLEEP_DEPTH_BIT_HI:lpmc_pkg::SLEEP_DEPTH_BIT_LO];
					r_next.mode  = depth_mode(r_next.depth);
				end
			end
			lpmc_pkg::LPMC_LIGHT,
			lpmc_pkg::LPMC_MEDIUM: begin
				if (wake) begin
					r_next.mode = lpmc_pkg::LPMC_RUN;
				end
			end
			lpmc_pkg::LPMC_DEEP: begin
				if (wake) begin
					r_next.mode = lpmc_pkg::LPMC_RESTART;
				end
			end
			lpmc_pkg::LPMC_RESTART: begin
				if (seq_cpu && !seq_busy) begin
					r_next.mode = lpmc_pkg::LPMC_RUN;
				end
			end
			default: r_next.mode = lpmc_pkg::LPMC_RUN;
		endcase

		// domain enables follow the state being entered
		// the sequencer still shows its idle release in the wake cycle, so mask it then
		r_next.cpu_en = (r_next.mode == lpmc_pkg::LPMC_RUN) ||
		                ((r_next.mode == lpmc_pkg::LPMC_RESTART) && seq_cpu && !seq_busy &&
		                 !seq_start);
		r_next.sys_en = (r_next.mode == lpmc_pkg::LPMC_RUN) ||
		                (r_next.mode == lpmc_pkg::LPMC_LIGHT) ||
		                ((r_next.mode == lpmc_pkg::LPMC_RESTART) && seq_sys && !seq_start);
		// only the deepest sleep drops the sources and the flash
		r_next.wd_en    = (r_next.mode != lpmc_pkg::LPMC_DEEP);
		r_next.pll_on   = (r_next.mode != lpmc_pkg::LPMC_DEEP);
		r_next.osc_on   = (r_next.mode != lpmc_pkg::LPMC_DEEP);
		r_next.flash_on = (r_next.mode != lpmc_pkg::LPMC_DEEP);

		// write address and data are taken in either order
		if (s_axi_awvalid && r_reg.awready) begin
			r_next.aw_addr = s_axi_awaddr;
			r_next.have_aw = 1'b1;
		end
		if (s_axi_wvalid && r_reg.wready) begin
			r_next.wdata  = s_axi_wdata;
			r_next.wstrb  = s_axi_wstrb;
			r_next.have_w = 1'b1;
		end

		// write response retires on bready
		if (r_reg.bvalid && s_axi_bready) begin
			r_next.bvalid = 1'b0;
		end

		// perform the write once both halves are here
		if (r_next.have_aw && r_next.have_w && !r_reg.bvalid) begin
			r_next.have_aw = 1'b0;
			r_next.have_w  = 1'b0;
			r_next.bvalid  = 1'b1;
			if (r_next.aw_addr[7:2] == lpmc_pkg::CTRL_OFS[7:2]) begin
				// enables may change at any time
				r_next.ctrl  = merge16(r_reg.ctrl, r_next.wdata, r_next.wstrb) & lpmc_pkg::CTRL_MASK;
				r_next.bresp = lpmc_pkg::RESP_OKAY;
			end else if (r_next.aw_addr[7:2] == lpmc_pkg::STAT_OFS[7:2]) begin
				r_next.bresp = lpmc_pkg::RESP_OKAY;  // read-only, write ignored
			end else begin
				r_next.bresp = lpmc_pkg::RESP_SLVERR;
			end
		end
		r_next.awready = !r_next.have_aw && !r_next.bvalid;
		r_next.wready  = !r_next.have_w && !r_next.bvalid;

		// read channel
		if (r_reg.rvalid && s_axi_rready) begin
			r_next.rvalid  = 1'b0;
			r_next.arready = 1'b1;
		end
		if (s_axi_arvalid && r_reg.arready) begin
			r_next.arready = 1'b0;
			r_next.rvalid  = 1'b1;
			r_next.rdata   = 32'h0000_0000;
			r_next.rresp   = lpmc_pkg::RESP_OKAY;
			if (s_axi_araddr[7:2] == lpmc_pkg::CTRL_OFS[7:2]) begin
				r_next.rdata[15:0] = r_reg.ctrl;
			end else if (s_axi_araddr[7:2] == lpmc_pkg::STAT_OFS[7:2]) begin
				// live enables, power state and restart activity
				r_next.rdata[lpmc_pkg::STAT_CPU_LSB +: 6] = {r_reg.flash_on, r_reg.osc_on, r_reg.pll_on,
				                                             r_reg.wd_en, r_reg.sys_en, r_reg.cpu_en};
				r_next.rdata[lpmc_pkg::STAT_MODE_LSB +: 3] = r_reg.mode;
				r_next.rdata[lpmc_pkg::STAT_BUSY_BIT]      = seq_busy;
			end else begin
				r_next.rresp = lpmc_pkg::RESP_SLVERR;
			end
		end

		// peripheral clocks run only with their bit set and the system domain on
		r_next.pclk = r_next.ctrl[lpmc_pkg::PCLK_EN_LSB +: lpmc_pkg::NUM_PCLK] &
		              {lpmc_pkg::NUM_PCLK{r_next.sys_en}};
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_reg          <= '0;
			r_reg.mode     <= lpmc_pkg::LPMC_RUN;  // reset ends any sleep
			r_reg.ctrl     <= lpmc_pkg::CTRL_RST;  // peripheral clocks start off
			r_reg.cpu_en   <= 1'b1;
			r_reg.sys_en   <= 1'b1;
			r_reg.wd_en    <= 1'b1;
			r_reg.pll_on   <= 1'b1;
			r_reg.osc_on   <= 1'b1;
			r_reg.flash_on <= 1'b1;
			r_reg.awready  <= 1'b1;
			r_reg.wready   <= 1'b1;
			r_reg.arready  <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all from flip-flops
	// ----------------------------------------------------------------
	assign cpu_clk_en          = r_reg.cpu_en;
	assign sys_clk_en          = r_reg.sys_en;
	assign cpu_clock_output_en = r_reg.sys_en;    // output clock feeds the system domain
	assign watchdog_clock_en   = r_reg.wd_en;
	assign pll_en              = r_reg.pll_on;
	assign osc_en              = r_reg.osc_on;
	assign flash_pwr_en        = r_reg.flash_on;
	assign periph_clk_en       = r_reg.pclk;
	assign s_axi_awready       = r_reg.awready;
	assign s_axi_wready        = r_reg.wready;
	assign s_axi_bvalid        = r_reg.bvalid;
	assign s_axi_bresp         = r_reg.bresp;
	assign s_axi_arready       = r_reg.arready;
	assign s_axi_rvalid        = r_reg.rvalid;
	assign s_axi_rdata         = r_reg.rdata;
	assign s_axi_rresp         = r_reg.rresp;

endmodule // lpmc_top

// ===== shared/lpmc_pkg.sv
// lpmc_pkg: constants and types shared by the low-power mode controller files
// assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus
package lpmc_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 20;
	localparam int SETTLE_TIME_NS   = 100;
	// least time, so round up to whole cycles
	localparam int SETTLE_CYC       = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W         = 4;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0]  CTRL_OFS        = 8'h00;
	localparam logic [7:0]  STAT_OFS        = 8'h04;
	localparam logic [15:0] CTRL_RST        = 16'h0000;
	localparam logic [15:0] CTRL_MASK       = 16'h30FC;

	// fields of system_control_status_one
	localparam int SLEEP_DEPTH_BIT_HI = 13;
	localparam int SLEEP_DEPTH_BIT_LO = 12;
	localparam int PCLK_EN_LSB        = 2;
	localparam int NUM_PCLK           = 6;

	// peripheral enable positions relative to PCLK_EN_LSB
	localparam int PCLK_EVENT_MANAGER_A = 0;
	localparam int PCLK_EVENT_MANAGER_B = 1;
	localparam int PCLK_CAN             = 2;
	localparam int PCLK_SPI             = 3;
	localparam int PCLK_SCI             = 4;
	localparam int PCLK_ADC             = 5;

	// fields of the status register
	localparam int STAT_CPU_LSB  = 0;
	localparam int STAT_MODE_LSB = 8;
	localparam int STAT_BUSY_BIT = 12;

	// ----------------------------------------------------------------
	// AXI responses
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// power states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LPMC_RUN,
		LPMC_LIGHT,
		LPMC_MEDIUM,
		LPMC_DEEP,
		LPMC_RESTART
	} lpmc_mode_t;

endpackage

// ===== hdl/lpmc_wake_sel.sv
// lpmc_wake_sel: picks the wake-up sources that count in the current sleep depth
// assumes interrupt inputs are levels synchronous to the system clock
`timescale 1ns/1ps
module lpmc_wake_sel (
	input  wire lpmc_pkg::lpmc_mode_t mode,
	input  wire logic                 periph_irq,
	input  wire logic                 ext_irq,
	input  wire logic                 wakeup_irq,
	input  wire logic                 drive_protect_interrupt,
	output logic                      wake
);

	// ----------------------------------------------------------------
	// source selection by depth
	// ----------------------------------------------------------------
	always_comb begin
		unique case (mode)
			lpmc_pkg::LPMC_LIGHT:  wake = periph_irq | ext_irq | drive_protect_interrupt;
			lpmc_pkg::LPMC_MEDIUM: wake = wakeup_irq | ext_irq | drive_protect_interrupt;
			lpmc_pkg::LPMC_DEEP:   wake = drive_protect_interrupt;
			default:               wake = 1'b0;
		endcase
	end

endmodule // lpmc_wake_sel

// ===== hdl/lpmc_restart_seq.sv
// lpmc_restart_seq: brings the clock domains back after the deepest sleep
// assumes osc_ready and pll_lock are synchronous levels from the clock source
`timescale 1ns/1ps
module lpmc_restart_seq (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic start,
	input  wire logic osc_ready,
	input  wire logic pll_lock,
	output logic      sys_release,
	output logic      cpu_release,
	output logic      busy
);

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_WAIT_SRC,
		SEQ_SETTLE,
		SEQ_SYS_ON
	} lpmc_seq_t;

	typedef struct packed {
		lpmc_seq_t                      st;
		logic [lpmc_pkg::SETTLE_W-1:0]  cnt;
		logic                           sys;
		logic                           cpu;
	} lpmc_seq_state_t;

	lpmc_seq_state_t s_reg;
	lpmc_seq_state_t s_next;

	// ----------------------------------------------------------------
	// sequence: sources up, settle, system domain, then cpu domain
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		unique case (s_reg.st)
			SEQ_IDLE: begin
				if (start) begin
					s_next.st  = SEQ_WAIT_SRC;
					s_next.sys = 1'b0;
					s_next.cpu = 1'b0;
				end
			end
			SEQ_WAIT_SRC: begin
				if (osc_ready && pll_lock) begin
					s_next.st  = SEQ_SETTLE;
					s_next.cnt = '0;
				end
			end
			SEQ_SETTLE: begin
				if (!(osc_ready && pll_lock)) begin
					s_next.st = SEQ_WAIT_SRC;  // lost lock, wait again
				end else if (s_next.cnt == lpmc_pkg::SETTLE_W'(lpmc_pkg::SETTLE_CYC - 1)) begin
					s_next.st  = SEQ_SYS_ON;
					s_next.sys = 1'b1;  // system domain first
				end else begin
					s_next.cnt = s_reg.cnt + 1'b1;
				end
			end
			SEQ_SYS_ON: begin
				s_next.st  = SEQ_IDLE;
				s_next.cpu = 1'b1;  // cpu domain one cycle later
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_reg <= '{st: SEQ_IDLE, cnt: '0, sys: 1'b1, cpu: 1'b1};
		end else begin
			s_reg <= s_next;
		end
	end

	assign sys_release = s_reg.sys;
	assign cpu_release = s_reg.cpu;
	assign busy        = (s_reg.st != SEQ_IDLE);

endmodule // lpmc_restart_seq

// ===== verif/lpmc_properties.sv
// lpmc_properties: concurrent checks on the low-power controller ports
// assumes it is bound into lpmc_top, one clock domain
`timescale 1ns/1ps
module lpmc_properties (
	input wire logic                           clk,
	input wire logic                           rst,
	input wire logic                           idle_exec,
	input wire logic                           periph_irq,
	input wire logic                           ext_irq,
	input wire logic                           wakeup_irq,
	input wire logic                           drive_protect_interrupt,
	input wire logic                           osc_ready,
	input wire logic                           pll_lock,
	input wire logic                           cpu_clk_en,
	input wire logic                           sys_clk_en,
	input wire logic                           cpu_clock_output_en,
	input wire logic                           watchdog_clock_en,
	input wire logic                           pll_en,
	input wire logic                           osc_en,
	input wire logic                           flash_pwr_en,
	input wire logic [lpmc_pkg::NUM_PCLK-1:0]  periph_clk_en
);
	// ----------------------------------------------------------------
	// helper state
	// ----------------------------------------------------------------
	logic [3:0] ok_cnt_reg;
	logic       deep_seen_reg;

	// counts settled clock-source cycles, remembers a deep sleep
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ok_cnt_reg    <= 4'h0;
			deep_seen_reg <= 1'b0;
		end else begin
			ok_cnt_reg    <= !(osc_ready && pll_lock) ? 4'h0 : (ok_cnt_reg == 4'hF) ? ok_cnt_reg : ok_cnt_reg + 4'h1;
			deep_seen_reg <= cpu_clk_en ? 1'b0 : (deep_seen_reg || !osc_en);
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_idle_taken;
		cpu_clk_en && idle_exec;
	endsequence
	sequence s_restart_rise;
		$rose(sys_clk_en) && !cpu_clk_en;
	endsequence

	chk_idle_cpu_stop: assert property (s_idle_taken |=> !cpu_clk_en)
		else $error("cpu domain kept running after idle");
	chk_output_clock: assert property (cpu_clock_output_en == sys_clk_en)
		else $error("cpu clock output differs from system domain");
	chk_domain_pair: assert property (cpu_clk_en |-> sys_clk_en)
		else $error("cpu domain on with system domain off");
	chk_deep_group: assert property (osc_en == pll_en && osc_en == watchdog_clock_en && osc_en == flash_pwr_en)
		else $error("deep sleep enables split");
	chk_deep_domains: assert property (!osc_en |-> !sys_clk_en && !cpu_clk_en)
		else $error("domain on with oscillator off");
	chk_run_holds: assert property (cpu_clk_en && !idle_exec |=> cpu_clk_en)
		else $error("cpu domain stopped without idle");
	chk_light_wake: assert property (!cpu_clk_en && sys_clk_en && !deep_seen_reg
		&& (periph_irq || ext_irq || drive_protect_interrupt) |=> cpu_clk_en)
		else $error("light sleep missed a wake source");
	chk_medium_wake: assert property (!sys_clk_en && osc_en && !deep_seen_reg
		&& (wakeup_irq || ext_irq || drive_protect_interrupt) |=> cpu_clk_en && sys_clk_en)
		else $error("medium sleep missed a wake source");
	chk_deep_hold: assert property (!osc_en && !drive_protect_interrupt |=> !osc_en)
		else $error("deep sleep left without drive protect");
	chk_deep_wake: assert property (!osc_en && drive_protect_interrupt |=> osc_en && !sys_clk_en)
		else $error("deep wake did not restart sources first");
	chk_restart_order: assert property (s_restart_rise |=> cpu_clk_en)
		else $error("cpu domain not one cycle after system domain");
	chk_restart_settle: assert property (s_restart_rise |-> ok_cnt_reg >= lpmc_pkg::SETTLE_CYC - 1)
		else $error("system domain released before sources settled");
	chk_periph_gated: assert property (!sys_clk_en |-> periph_clk_en == '0)
		else $error("peripheral clock on with system domain off");
endmodule // lpmc_properties

bind lpmc_top lpmc_properties lpmc_properties_inst (.clk(clk), .rst(rst), .idle_exec(idle_exec),
	.periph_irq(periph_irq), .ext_irq(ext_irq), .wakeup_irq(wakeup_irq),
	.drive_protect_interrupt(drive_protect_interrupt), .osc_ready(osc_ready), .pll_lock(pll_lock),
	.cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en), .cpu_clock_output_en(cpu_clock_output_en),
	.watchdog_clock_en(watchdog_clock_en), .pll_en(pll_en), .osc_en(osc_en),
	.flash_pwr_en(flash_pwr_en), .periph_clk_en(periph_clk_en));

// ===== verif/lpmc_clk_src_model.sv
// lpmc_clk_src_model: oscillator and pll seen from the controller
// assumes enables come from lpmc_top; ready flags fall as soon as power goes
`timescale 1ns/1ps
module lpmc_clk_src_model #(
	parameter int OSC_DLY  = 3,
	parameter int LOCK_DLY = 2
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic osc_en,
	input  wire logic pll_en,
	input  wire logic drop_lock,
	output logic      osc_ready,
	output logic      pll_lock
);
	int osc_cnt;
	int lock_cnt;

	// start-up delay of the oscillator, then of the pll lock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			osc_cnt  <= OSC_DLY;
			lock_cnt <= LOCK_DLY;
		end else begin
			osc_cnt  <= !osc_en ? 0 : (osc_cnt < OSC_DLY) ? osc_cnt + 1 : osc_cnt;
			lock_cnt <= (!pll_en || !osc_ready || drop_lock) ? 0 : (lock_cnt < LOCK_DLY) ? lock_cnt + 1 : lock_cnt;
		end
	end
	assign osc_ready = osc_en && osc_cnt >= OSC_DLY;
	assign pll_lock  = osc_ready && lock_cnt >= LOCK_DLY;
endmodule // lpmc_clk_src_model

// ===== verif/tb.sv
// tb: self-checking bench of the low-power mode controller
// assumes lpmc_top, its checker and the clock source model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        idle_exec = 1'b0;
	logic [3:0]  irq = 4'h0; // periph, ext, wakeup, drive protect
	logic        drop_lock = 1'b0;
	logic        osc_ready;
	logic        pll_lock;
	logic        cpu_clk_en, sys_clk_en, out_en, wd_en, pll_en, osc_en, flash_en;
	logic [5:0]  periph_clk_en;
	logic [6:0]  en;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	int          errors = 0;
	int          compares = 0;
	int          cyc = 0;

	// ----------------------------------------------------------------
	// clock, design and far side
	// ----------------------------------------------------------------
	always #10 clk = ~clk;
	assign en = {cpu_clk_en, sys_clk_en, out_en, wd_en, pll_en, osc_en, flash_en};
	lpmc_top lpmc_top_inst (.clk(clk), .rst(rst), .idle_exec(idle_exec), .periph_irq(irq[3]), .ext_irq(irq[2]),
		.wakeup_irq(irq[1]), .drive_protect_interrupt(irq[0]), .osc_ready(osc_ready), .pll_lock(pll_lock),
		.cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en), .cpu_clock_output_en(out_en),
		.watchdog_clock_en(wd_en), .pll_en(pll_en), .osc_en(osc_en), .flash_pwr_en(flash_en),
		.periph_clk_en(periph_clk_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	lpmc_clk_src_model lpmc_clk_src_model_inst (.clk(clk), .rst(rst), .osc_en(osc_en), .pll_en(pll_en),
		.drop_lock(drop_lock), .osc_ready(osc_ready), .pll_lock(pll_lock));

	// ----------------------------------------------------------------
	// bus and pulse tasks
	// ----------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			if (!aw_ok && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clk);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge clk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic irq_go(input logic [3:0] v);
		@(posedge clk);
		irq <= v;
		@(posedge clk);
		irq <= 4'h0;
		#1;
	endtask

	task automatic idle_go;
		@(posedge clk);
		idle_exec <= 1'b1;
		@(posedge clk);
		idle_exec <= 1'b0;
		#1;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		#1;
		`CHK("reset enables", 7'h7F, en)
		`CHK("reset periph", 6'h00, periph_clk_en)
		axi_rd(8'h00, d, r);
		`CHK("reset ctrl", 32'h0, d)
		$display("test reset done");
	endtask

	task automatic t_periph;
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < lpmc_pkg::NUM_PCLK; i++) begin
			axi_wr(8'h00, 32'h4 << i, r);
			#1;
			`CHK("periph on", 6'h01 << i, periph_clk_en)
			axi_rd(8'h00, d, r);
			`CHK("ctrl readback", 32'h4 << i, d)
		end
		axi_wr(8'h08, 32'hFFFF, r);
		`CHK("unmapped write", lpmc_pkg::RESP_SLVERR, r)
		axi_rd(8'h08, d, r);
		`CHK("unmapped read", lpmc_pkg::RESP_SLVERR, r)
		axi_wr(8'h00, 32'h0, r);
		#1;
		`CHK("periph off", 6'h00, periph_clk_en)
		$display("test periph done");
	endtask

	// enter a depth, refuse wrong sources, wake on the right one
	task automatic t_sleep(input logic [15:0] c, input logic [6:0] e, input logic [3:0] bad,
		input logic [3:0] good, input logic glitch);
		logic [1:0] r;
		int         n;
		axi_wr(8'h00, {16'h0, c}, r);
		#1;
		`CHK("run enables", 7'h7F, en)
		idle_go();
		`CHK("sleep enables", e, en)
		`CHK("sleep periph", e[5] ? c[7:2] : 6'h00, periph_clk_en)
		irq_go(bad);
		`CHK("no wake", e, en)
		idle_go();
		`CHK("idle ignored", e, en)
		irq_go(good);
		if (!e[0]) begin
			`CHK("restart sources", 7'h0F, en)
			n = 0;
			while (!sys_clk_en && n < 40) begin
				@(posedge clk);
				drop_lock <= glitch && n == 6;
				#1;
				n++;
			end
			`CHK("cpu held", 1'b0, cpu_clk_en)
			`CHK("settled", 1'b1, n >= lpmc_pkg::SETTLE_CYC)
			@(posedge clk);
			#1;
		end
		`CHK("woken", 7'h7F, en)
		$display("test sleep %0h done", c);
	endtask

	task automatic t_rst_wake;
		logic [1:0] r;
		axi_wr(8'h00, 32'h100C, r);
		idle_go();
		`CHK("medium", 7'h0F, en)
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK("reset wake", 7'h7F, en)
		`CHK("reset periph", 6'h00, periph_clk_en)
		$display("test reset wake done");
	endtask

	// ----------------------------------------------------------------
	// verdict, timeout and main sequence
	// ----------------------------------------------------------------
	task end_sim;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors = errors + 1;
			end_sim();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_periph();
		t_sleep(16'h000C, 7'h3F, 4'b0010, 4'b1000, 1'b0);
		t_sleep(16'h0030, 7'h3F, 4'b0010, 4'b0100, 1'b0);
		t_sleep(16'h00C0, 7'h3F, 4'b0010, 4'b0001, 1'b0);
		t_sleep(16'h100C, 7'h0F, 4'b1000, 4'b0010, 1'b0);
		t_sleep(16'h1030, 7'h0F, 4'b1000, 4'b0100, 1'b0);
		t_sleep(16'h10C0, 7'h0F, 4'b1000, 4'b0001, 1'b0);
		t_sleep(16'h200C, 7'h00, 4'b1110, 4'b0001, 1'b0);
		t_sleep(16'h3000, 7'h00, 4'b1110, 4'b0001, 1'b1);
		t_rst_wake();
		end_sim();
	end
endmodule // tb
